// File: spi_master_ctrl.sv
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "spi_defs.svh"
module spi_master_ctrl
  import spi_pkg::*;
(
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // AXI4-Lite write
  input  wire logic [7:0] awaddr,
  input  wire logic       awvalid,
  output logic            awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0] wstrb,
  input  wire logic       wvalid,
  output logic            wready,
  output logic [1:0]      bresp,
  output logic            bvalid,
  input  wire logic       bready,
  // AXI4-Lite read
  input  wire logic [7:0] araddr,
  input  wire logic       arvalid,
  output logic            arready,
  output logic [31:0]     rdata,
  output logic [1:0]      rresp,
  output logic            rvalid,
  input  wire logic       rready,
  // Serial link
  output logic            chip_select_n,
  output logic            serial_clock_out,
  output logic            serial_data_out,
  input  wire logic       serial_in_line_one,
  input  wire logic       serial_in_line_two,
  // Interrupt
  output logic            irq
);
  logic       aw_got_r, w_got_r;
  logic [7:0] waddr_r;
  logic [31:0] wdat_r;
  logic       enable_r;
  logic [6:0] ctrl_r;
  logic [1:0] status_r, mask_r, phase_r;
  logic [7:0] tx_hold_r, tx_sh_r, rx_sh_r, rx_data_r;
  logic       tx_pend_r, soft_rst_r, rst_all;
  eng_state_e state_r;
  logic [2:0] div_r;
  logic [4:0] edge_r;
  logic [1:0] s1_r, s2_r, s3_r, in_hold_r, in_v;
  logic       wr_go, rd_go, wr_ok, rd_rx;
  logic       tick, odd_edge, samp_ev, drv_ev, last_edge, start, rx_set, tx_set;
  logic [4:0] edges;
  logic [7:0] rx_nxt;
  logic [31:0] rd_val;

  assign rst_all = !aresetn || soft_rst_r;

  // Write path: address and data taken in either order
  assign awready = !aw_got_r && !bvalid;
  assign wready  = !w_got_r && !bvalid;
  assign wr_go   = aw_got_r && w_got_r && !bvalid;
  assign wr_ok   = waddr_r == `REG_ENABLE || waddr_r == `REG_CONTROL
                || waddr_r == `REG_STATUS || waddr_r == `REG_MASK
                || waddr_r == `REG_TXDATA || waddr_r == `REG_PHASE;

  // Bus handshake sees only the pin reset, so a soft reset still answers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      waddr_r  <= 8'h00;
      wdat_r   <= 32'h0;
      bvalid   <= 1'b0;
      bresp    <= `RESP_OKAY;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_got_r <= 1'b1;
        waddr_r  <= awaddr;
      end
      if (wvalid && wready)
      begin
        w_got_r <= 1'b1;
        wdat_r  <= wdata;
      end
      if (wr_go)
      begin
        bvalid   <= 1'b1;
        bresp    <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  // Read path
  assign arready = !rvalid;
  assign rd_go   = arvalid && arready;
  assign rd_rx   = rd_go && araddr == `REG_RXDATA;

  always_comb
  begin
    rd_val = 32'h0;
    case (araddr)
      `REG_ENABLE:  rd_val = {31'h0, enable_r};
      `REG_CONTROL: rd_val = {25'h0, ctrl_r};
      `REG_STATUS:  rd_val = {30'h0, status_r};
      `REG_MASK:    rd_val = {30'h0, mask_r};
      `REG_TXDATA:  rd_val = {24'h0, tx_hold_r};
      `REG_RXDATA:  rd_val = {24'h0, rx_data_r};
      `REG_PHASE:   rd_val = {30'h0, phase_r};
      default:      rd_val = 32'h0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata  <= 32'h0;
      rresp  <= `RESP_OKAY;
    end
    else if (rd_go)
    begin
      rvalid <= 1'b1;
      rdata  <= rd_val;
      rresp  <= (araddr > `REG_PHASE || araddr[1:0] != 2'h0) ? `RESP_SLVERR : `RESP_OKAY;
    end
    else if (rready)
      rvalid <= 1'b0;
  end

  // Configuration registers; only byte lane 0 carries fields
  always_ff @(posedge aclk)
  begin
    if (rst_all)
    begin
      enable_r  <= 1'b0;
      ctrl_r    <= `CTRL_RST;
      mask_r    <= 2'h0;
      phase_r   <= 2'h0;
      tx_hold_r <= 8'h00;
    end
    else if (wr_go && wstrb[0])
    begin
      case (waddr_r)
        `REG_ENABLE:  enable_r  <= wdat_r[`EN_BIT];
        `REG_CONTROL: ctrl_r    <= {wdat_r[`CS_BIT:`AUTO_BIT], 1'b0,
                                    wdat_r[`SEL_HI:`SEL_LO], 2'b00};
        `REG_MASK:    mask_r    <= wdat_r[1:0];
        `REG_PHASE:   phase_r   <= wdat_r[1:0];
        `REG_TXDATA:  tx_hold_r <= wdat_r[7:0];
        default:      ;
      endcase
    end
  end

  // Self-clearing soft reset pulse; a written zero does nothing
  always_ff @(posedge aclk)
  begin
    if (rst_all)
      soft_rst_r <= 1'b0;
    else
      soft_rst_r <= wr_go && wstrb[0] && waddr_r == `REG_CONTROL
                 && wdat_r[`SRST_BIT];
  end

  // Status: hardware set wins over any clear in the same cycle
  always_ff @(posedge aclk)
  begin
    if (rst_all)
      status_r <= `STS_RST;
    else
    begin
      if (rx_set)
        status_r[`RXF_BIT] <= 1'b1;
      else if (rd_rx || (wr_go && waddr_r == `REG_STATUS && wdat_r[`RXF_BIT]))
        status_r[`RXF_BIT] <= 1'b0;
      if (tx_set)
        status_r[`TXE_BIT] <= 1'b1;
      else if ((rd_rx && ctrl_r[`AUTO_BIT])
               || (wr_go && waddr_r == `REG_TXDATA)
               || (wr_go && waddr_r == `REG_STATUS && wdat_r[`TXE_BIT]))
        status_r[`TXE_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (rst_all)
    begin
      irq           <= 1'b0;
      chip_select_n <= 1'b1;
    end
    else
    begin
      irq           <= |(status_r & mask_r);
      chip_select_n <= !ctrl_r[`CS_BIT];
    end
  end

  // Serial inputs: three stages, a change counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_sync
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          s1_r[gi]      <= 1'b0;
          s2_r[gi]      <= 1'b0;
          s3_r[gi]      <= 1'b0;
          in_hold_r[gi] <= 1'b0;
        end
        else
        begin
          s1_r[gi]      <= gi == 0 ? serial_in_line_one : serial_in_line_two;
          s2_r[gi]      <= s1_r[gi];
          s3_r[gi]      <= s2_r[gi];
          in_hold_r[gi] <= in_v[gi];
        end
      end
      assign in_v[gi] = (s2_r[gi] == s3_r[gi]) ? s3_r[gi] : in_hold_r[gi];
    end
  endgenerate

  // Engine timing
  assign edges     = ctrl_r[`SEL_HI] ? `EDGES_DUAL : `EDGES_SINGLE;
  assign start     = state_r == ST_IDLE && enable_r && tx_pend_r;
  assign tick      = state_r == ST_RUN && enable_r && div_r == `HALF_CYC - 3'h1;
  assign odd_edge  = !edge_r[0];
  assign samp_ev   = tick && (odd_edge != phase_r[`PH_RX_BIT]);
  assign drv_ev    = tick && (odd_edge == phase_r[`PH_TX_BIT]);
  assign last_edge = tick && edge_r == edges - 5'h1;
  assign rx_set    = last_edge;
  assign tx_set    = start;

  always_comb
  begin
    case (ctrl_r[`SEL_HI:`SEL_LO])
      2'b00:   rx_nxt = {rx_sh_r[6:0], in_v[0]};
      2'b01:   rx_nxt = {rx_sh_r[6:0], in_v[1]};
      default: rx_nxt = {rx_sh_r[5:0], in_v[1], in_v[0]};
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (rst_all)
      tx_pend_r <= 1'b0;
    else if (wr_go && waddr_r == `REG_TXDATA)
      tx_pend_r <= 1'b1;
    else if (start)
      tx_pend_r <= 1'b0;
  end

  // Disable drops a frame in flight: clock and data fall back to idle
  always_ff @(posedge aclk)
  begin
    if (rst_all || !enable_r)
    begin
      state_r         <= ST_IDLE;
      div_r           <= 3'h0;
      edge_r          <= 5'h00;
      serial_clock_out <= 1'b0;
      serial_data_out <= 1'b0;
      tx_sh_r         <= 8'h00;
      rx_sh_r         <= 8'h00;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
          if (start)
          begin
            state_r <= ST_RUN;
            div_r   <= 3'h0;
            edge_r  <= 5'h00;
            if (!phase_r[`PH_TX_BIT])
            begin
              serial_data_out <= tx_hold_r[7];
              tx_sh_r         <= {tx_hold_r[6:0], 1'b0};
            end
            else
              tx_sh_r <= tx_hold_r;
          end
        ST_RUN:
        begin
          div_r <= tick ? 3'h0 : div_r + 3'h1;
          if (tick)
          begin
            serial_clock_out <= !serial_clock_out;
            edge_r           <= edge_r + 5'h1;
          end
          if (samp_ev)
            rx_sh_r <= rx_nxt;
          if (drv_ev)
          begin
            serial_data_out <= tx_sh_r[7];
            tx_sh_r         <= {tx_sh_r[6:0], 1'b0};
          end
          if (last_edge)
            state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (rst_all)
      rx_data_r <= 8'h00;
    else if (last_edge)
      rx_data_r <= samp_ev ? rx_nxt : rx_sh_r;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_disable_idles_link: assert property (!enable_r |=> !serial_clock_out && !serial_data_out)
    else $error("link not idle while disabled");
  a_cs_follows_bit: assert property (!soft_rst_r |=> chip_select_n == !$past(ctrl_r[`CS_BIT]))
    else $error("chip select does not follow control");
  a_auto_read_both: assert property (rd_rx && ctrl_r[`AUTO_BIT] && !rx_set && !tx_set && !soft_rst_r
    |=> status_r == 2'h0)
    else $error("auto read left a flag set");
  a_plain_read_rxf: assert property (rd_rx && !ctrl_r[`AUTO_BIT] && !rx_set && !tx_set && !wr_go
    && !soft_rst_r |=> !status_r[`RXF_BIT] && $stable(status_r[`TXE_BIT]))
    else $error("plain read changed wrong flag");
  a_soft_reset_all: assert property (soft_rst_r |=> !enable_r && ctrl_r == `CTRL_RST
    && state_r == ST_IDLE && !soft_rst_r)
    else $error("soft reset incomplete");
  a_select_line_one: assert property (samp_ev && ctrl_r[`SEL_HI:`SEL_LO] == 2'b00
    && !last_edge |=> rx_sh_r[0] == $past(in_v[0]))
    else $error("line one not sampled");
  a_select_line_two: assert property (samp_ev && ctrl_r[`SEL_HI:`SEL_LO] == 2'b01
    && !last_edge |=> rx_sh_r[0] == $past(in_v[1]))
    else $error("line two not sampled");
  a_reset_defaults: assert property ($rose(aresetn) |-> !enable_r && ctrl_r == `CTRL_RST)
    else $error("register not zero after reset");
  // Odd edges of an idle-low clock are its rising edges
  a_phase0_sample_odd: assert property (samp_ev && !phase_r[`PH_RX_BIT] |-> !serial_clock_out)
    else $error("sample off odd edge");
  a_phase1_drive_late: assert property (start && phase_r[`PH_TX_BIT]
    |=> $stable(serial_data_out) [*4])
    else $error("data driven before first edge");
  a_irq_level: assert property (!soft_rst_r |=> irq == |($past(status_r) & $past(mask_r)))
    else $error("interrupt level wrong");

  c_transfer_done: cover property (last_edge);
  c_auto_read: cover property (rd_rx && ctrl_r[`AUTO_BIT] && status_r == 2'h3);
  c_soft_reset: cover property (soft_rst_r);
  c_dual_done: cover property (last_edge && ctrl_r[`SEL_HI]);
endmodule : spi_master_ctrl
`default_nettype wire

// File: spi_defs.svh
`ifndef SPI_DEFS_SVH
`define SPI_DEFS_SVH
// Register byte offsets
`define REG_ENABLE      8'h00
`define REG_CONTROL     8'h04
`define REG_STATUS      8'h08
`define REG_MASK        8'h0c
`define REG_TXDATA      8'h10
`define REG_RXDATA      8'h14
`define REG_PHASE       8'h18
// Field positions
`define EN_BIT          0
`define CS_BIT          6
`define AUTO_BIT        5
`define SRST_BIT        4
`define SEL_HI          3
`define SEL_LO          2
`define RXF_BIT         0
`define TXE_BIT         1
`define PH_TX_BIT       0
`define PH_RX_BIT       1
// Reset values
`define CTRL_RST        7'h00
`define STS_RST         2'h2
// Bus answers
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
// Timing
`define CLK_PERIOD_NS   100
`define SCLK_HALF_NS    400
`define HALF_CYC        3'((`SCLK_HALF_NS) / (`CLK_PERIOD_NS))
`define EDGES_SINGLE    5'h10
`define EDGES_DUAL      5'h08
`endif

// File: spi_pkg.sv
package spi_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } eng_state_e;
endpackage : spi_pkg

// File: spi_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_slave_model
(
  // Link
  input  wire logic       chip_select_n,
  input  wire logic       serial_clock_out,
  input  wire logic       serial_data_out,
  output logic            serial_in_line_one,
  output logic            serial_in_line_two,
  // Scenario: 0 line one, 1 line two, 2 dual
  input  wire logic [1:0] mode,
  input  wire logic [7:0] tx_byte,
  output logic [7:0]      rx_byte
);
  logic [7:0] sh_r;
  initial
  begin
    serial_in_line_one = 1'b0;
    serial_in_line_two = 1'b1;
    rx_byte = 8'h00;
    sh_r = 8'h00;
  end
  // Unused line toggles so a wrong select cannot pass by luck
  task automatic drive();
    serial_in_line_one = (mode == 2'h0) ? sh_r[7] : (mode[1] ? sh_r[6] : ~serial_in_line_one);
    serial_in_line_two = (mode == 2'h0) ? ~serial_in_line_two : sh_r[7];
  endtask : drive
  always @(negedge chip_select_n)
  begin
    sh_r = tx_byte;
    drive();
  end
  always @(negedge serial_clock_out)
  begin
    if (!chip_select_n)
      sh_r = mode[1] ? (sh_r << 2) : (sh_r << 1);
    drive();
  end
  always @(posedge serial_clock_out)
    if (!chip_select_n)
      rx_byte = {rx_byte[6:0], serial_data_out};
  always @(posedge chip_select_n)
  begin
    serial_in_line_one = ~serial_in_line_one;
    serial_in_line_two = ~serial_in_line_two;
  end
endmodule : spi_slave_model
`default_nettype wire

// File: spi_master_enable_control_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "spi_defs.svh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module spi_master_enable_control_test;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, b;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic        chip_select_n, serial_clock_out, serial_data_out;
  logic        serial_in_line_one, serial_in_line_two;
  logic [7:0]  awaddr, araddr, slv_tx, slv_rx;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, slv_mode;
  int          fail_count, cmp_count, rise_cnt;
  spi_master_ctrl spi_master_ctrl_inst (.aclk, .aresetn, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .chip_select_n, .serial_clock_out,
    .serial_data_out, .serial_in_line_one, .serial_in_line_two, .irq);
  spi_slave_model spi_slave_model_inst (.chip_select_n, .serial_clock_out,
    .serial_data_out, .serial_in_line_one, .serial_in_line_two, .mode(slv_mode),
    .tx_byte(slv_tx), .rx_byte(slv_rx));
  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  always @(posedge serial_clock_out) rise_cnt++;
  task automatic tally_and_finish();
    $display("fail_count=%0d cmp_count=%0d", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  task automatic guard(input int n, input int lim);
    if (n >= lim)
    begin
      fail_count++;
      $display("MISMATCH timeout exp %0d got %0d", lim - 1, n);
      tally_and_finish();
    end
  endtask : guard
  task automatic settle();
    repeat (3) @(negedge aclk);
  endtask : settle
  // Ready is sampled mid-cycle; it cannot change before the next rising edge
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int   n;
    logic pa, pw, ta, tw;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    n = 0;
    while ((pa || pw) && n < 50)
    begin
      @(negedge aclk);
      ta = pa & awready;
      tw = pw & wready;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      pa = pa & ~ta;
      pw = pw & ~tw;
      n++;
    end
    guard(n, 50);
    do
    begin
      @(negedge aclk);
      n++;
    end
    while (bvalid !== 1'b1 && n < 100);
    guard(n, 100);
    `CHK("bresp", er, bresp)
    @(posedge aclk);
    bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a, input logic [1:0] er);
    int   n;
    logic ta;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do
    begin
      @(negedge aclk);
      ta = arready;
      @(posedge aclk);
      n++;
    end
    while (ta !== 1'b1 && n < 50);
    guard(n, 50);
    arvalid <= 1'b0;
    do
    begin
      @(negedge aclk);
      n++;
    end
    while (rvalid !== 1'b1 && n < 100);
    guard(n, 100);
    rd = rdata;
    `CHK("rresp", er, rresp)
    @(posedge aclk);
    rready <= 1'b0;
  endtask : axr
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    axr(a, `RESP_OKAY);
    `CHK("rdata", e, rd)
  endtask : rchk
  task automatic xfer(input logic [31:0] c, input logic [1:0] m, input logic [7:0] s, t,
                      input int e);
    int n;
    axw(`REG_CONTROL, c, `RESP_OKAY);
    slv_mode <= m;
    slv_tx <= s;
    axw(`REG_CONTROL, c | 32'h40, `RESP_OKAY);
    rise_cnt = 0;
    axw(`REG_TXDATA, {24'h0, t}, `RESP_OKAY);
    n = 0;
    do
    begin
      axr(`REG_STATUS, `RESP_OKAY);
      n++;
    end
    while (rd[0] !== 1'b1 && n < 100);
    guard(n, 100);
    `CHK("edges", e, rise_cnt)
  endtask : xfer
  task automatic t_regs();
    rchk(`REG_ENABLE, 32'h0);
    rchk(`REG_CONTROL, 32'h0);
    `CHK("cs_n", 1'b1, chip_select_n)
    axw(`REG_ENABLE, 32'hffffffff, `RESP_OKAY);
    rchk(`REG_ENABLE, 32'h1);
    axw(`REG_CONTROL, 32'hffffffef, `RESP_OKAY);
    rchk(`REG_CONTROL, 32'h6c);
    settle();
    `CHK("cs_n", 1'b0, chip_select_n)
    axw(`REG_CONTROL, 32'h0, `RESP_OKAY);
    settle();
    `CHK("cs_n", 1'b1, chip_select_n)
    axw(8'h20, 32'h1, `RESP_SLVERR);
    axw(`REG_RXDATA, 32'h1, `RESP_SLVERR);
    axr(8'h22, `RESP_SLVERR);
  endtask : t_regs
  task automatic t_frames();
    axw(`REG_MASK, 32'h1, `RESP_OKAY);
    xfer(32'h00, 2'h0, 8'ha5, 8'h3c, 8);
    `CHK("slave_rx", 8'h3c, slv_rx)
    settle();
    `CHK("irq", 1'b1, irq)
    axw(`REG_MASK, 32'h0, `RESP_OKAY);
    settle();
    `CHK("irq", 1'b0, irq)
    axw(`REG_MASK, 32'h1, `RESP_OKAY);
    settle();
    `CHK("irq", 1'b1, irq)
    rchk(`REG_RXDATA, 32'ha5);
    rchk(`REG_STATUS, 32'h2);
    settle();
    `CHK("irq", 1'b0, irq)
    xfer(32'h20, 2'h0, 8'hc3, 8'h5a, 8);
    rchk(`REG_RXDATA, 32'hc3);
    rchk(`REG_STATUS, 32'h0);
    xfer(32'h04, 2'h1, 8'h96, 8'h69, 8);
    axw(`REG_STATUS, 32'h1, `RESP_OKAY);
    rchk(`REG_STATUS, 32'h2);
    rchk(`REG_RXDATA, 32'h96);
    xfer(32'h08, 2'h2, 8'h5a, 8'h00, 4);
    rchk(`REG_RXDATA, 32'h5a);
  endtask : t_frames
  // Frame left running on purpose so that disabling aborts it
  task automatic t_phase_abort();
    int n;
    axw(`REG_PHASE, 32'h1, `RESP_OKAY);
    axw(`REG_TXDATA, 32'h80, `RESP_OKAY);
    n = 0;
    b = 1'b0;
    while (serial_clock_out !== 1'b1 && n < 100)
    begin
      b = b | serial_data_out;
      @(negedge aclk);
      n++;
    end
    guard(n, 100);
    `CHK("sdo_early", 1'b0, b)
    settle();
    `CHK("sdo_late", 1'b1, serial_data_out)
    axw(`REG_ENABLE, 32'h0, `RESP_OKAY);
    axw(`REG_TXDATA, 32'hff, `RESP_OKAY);
    b = 1'b0;
    repeat (100)
    begin
      @(negedge aclk);
      b = b | serial_clock_out | serial_data_out;
    end
    `CHK("idle", 1'b0, b)
  endtask : t_phase_abort
  task automatic t_soft();
    axw(`REG_ENABLE, 32'h1, `RESP_OKAY);
    axw(`REG_CONTROL, 32'h70, `RESP_OKAY);
    rchk(`REG_CONTROL, 32'h0);
    rchk(`REG_ENABLE, 32'h0);
    rchk(`REG_PHASE, 32'h0);
    rchk(`REG_STATUS, 32'h2);
    `CHK("cs_n", 1'b1, chip_select_n)
  endtask : t_soft
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, aresetn} = 6'h00;
    {awaddr, araddr, slv_tx, slv_mode} = 26'h0;
    wdata = 32'h0;
    wstrb = 4'hf;
    {fail_count, cmp_count, rise_cnt} = {32'h0, 32'h0, 32'h0};
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_frames();
    t_phase_abort();
    t_soft();
    tally_and_finish();
  end
endmodule : spi_master_enable_control_test
`default_nettype wire
